// ==== rtl/nbr_pkg.sv ====
// Package: constants, register map and types of the northbridge request router
package nbr_pkg;
   // Configuration space geometry
   localparam int unsigned BASE_REGION_BYTES = 256;
   localparam int unsigned FUNC_SPACE_LAST = 4095;
   localparam logic [7:0] NODE_DEV_FIRST = 8'h18;
   localparam logic [7:0] NODE_DEV_LAST = 8'h1F;
   localparam logic [15:0] PORT_ADDR_IO = 16'h0CF8;
   localparam logic [15:0] PORT_DATA_IO = 16'h0CFC;
   localparam logic [47:0] LINK_BASE_CFG_ADDR = 48'hFD_FE00_0000;
   localparam logic [47:0] LINK_EXT_CFG_ADDR = 48'hFE_0000_0000;
   localparam logic [31:0] UNIMPL_REG_DATA = 32'h0000_0000;
   localparam logic [31:0] UNIMPL_FUNC_DATA = 32'hFFFF_FFFF;

   // APB register offsets (byte addresses)
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_MMCFG_BASE = 12'h004;
   localparam logic [11:0] REG_MMIO_BASE = 12'h008;
   localparam logic [11:0] REG_MMIO_LIMIT = 12'h00C;
   localparam logic [11:0] REG_DRAM_BASE = 12'h010;
   localparam logic [11:0] REG_DRAM_LIMIT = 12'h014;
   localparam logic [11:0] REG_IO_BASE = 12'h018;
   localparam logic [11:0] REG_IO_LIMIT = 12'h01C;
   localparam logic [11:0] REG_CFGMAP = 12'h020;
   localparam logic [11:0] REG_STATUS = 12'h024;
   localparam logic [11:0] REG_SCRATCH = 12'h028;

   // Control register fields and register reset values
   localparam int unsigned CTRL_PORT_CFG_EN = 0;
   localparam int unsigned CTRL_PORT_EXT_EN = 1;
   localparam int unsigned CTRL_PORT_FAULT_EN = 2;
   localparam int unsigned CTRL_VGA_EN = 3;
   localparam int unsigned CTRL_MMCFG_EN = 4;
   localparam int unsigned CTRL_BUSN_LSB = 8;
   localparam int unsigned CTRL_SUBLINK_LSB = 12;
   localparam int unsigned CTRL_FUNCS_LSB = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] MMCFG_BASE_RESET = 32'hE000_0000;
   localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
   localparam logic [31:0] BASE_RESET = 32'hFFFF_FFFF;
   // Configuration map: [7:0] bus lo, [15:8] bus hi, [17:16] link, [31] valid
   localparam int unsigned CFGMAP_VALID = 31;
   localparam int unsigned CFGMAP_LINK_LSB = 16;

   // VGA compatible windows
   localparam logic [31:0] VGA_MEM_LO = 32'h000A_0000;
   localparam logic [31:0] VGA_MEM_HI = 32'h000B_FFFF;
   localparam logic [31:0] VGA_IO_LO = 32'h0000_03B0;
   localparam logic [31:0] VGA_IO_HI = 32'h0000_03DF;

   typedef enum logic [1:0] {
      NBR_SPACE_MEM = 2'h0,
      NBR_SPACE_IO = 2'h1,
      NBR_SPACE_CFG = 2'h2
   } nbr_space_e;

   // One-hot destinations; none is all zeros
   typedef enum logic [5:0] {
      NBR_DST_NONE = 6'h00,
      NBR_DST_DRAM = 6'h01,
      NBR_DST_ROOT = 6'h02,
      NBR_DST_LEGACY = 6'h04,
      NBR_DST_VGA = 6'h08,
      NBR_DST_LINK = 6'h10,
      NBR_DST_ABORT = 6'h20
   } nbr_dst_e;

   typedef enum logic [3:0] {
      NBR_ST_IDLE = 4'h1,
      NBR_ST_ROUTE = 4'h2,
      NBR_ST_WAIT = 4'h4,
      NBR_ST_DONE = 4'h8
   } nbr_state_e;
endpackage

// ==== rtl/nbr_router.sv ====
// Northbridge request router: config access paths and address space routing
`timescale 1ns/1ps
module nbr_router #(
   parameter int unsigned NUM_REGS = 64,
   parameter int unsigned LINK_W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request port
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_from_core,
   input wire logic [1:0] req_space,
   input wire logic req_dst_dram,
   input wire logic req_write,
   input wire logic req_posted,
   input wire logic req_port_io,
   input wire logic [47:0] req_addr,
   input wire logic [31:0] req_wdata,
   // Routed answer
   output logic rsp_valid,
   output logic [5:0] rsp_dst,
   output logic [47:0] rsp_addr,
   output logic [31:0] rsp_rdata,
   output logic rsp_fault,
   output logic [LINK_W-1:0] rsp_link,
   // Completion of a forwarded config cycle, from the far side
   input wire logic cfg_done,
   input wire logic cfg_master_abort
);
   import nbr_pkg::*;

   initial begin
      if (NUM_REGS < 1 || NUM_REGS > 1024 || LINK_W < 1 || LINK_W > 2)
         $error("nbr_router: unsupported parameters");
   end

   typedef struct packed {
      nbr_state_e st;
      logic [31:0] ctrl;
      logic [31:0] mmcfg_base;
      logic [31:0] mmio_base;
      logic [31:0] mmio_limit;
      logic [31:0] dram_base;
      logic [31:0] dram_limit;
      logic [31:0] io_base;
      logic [31:0] io_limit;
      logic [31:0] cfgmap;
      logic [31:0] scratch;
      logic [31:0] port_addr;
      logic [15:0] abort_cnt;
      logic cfg_pending;
      logic [31:0] prdata;
      logic rsp_valid;
      logic [5:0] rsp_dst;
      logic [47:0] rsp_addr;
      logic [31:0] rsp_rdata;
      logic rsp_fault;
      logic [LINK_W-1:0] rsp_link;
   } nbr_state_s;

   nbr_state_s cur_ff;
   nbr_state_s nxt_cur;

   // Decoded configuration target
   logic [7:0] c_bus;
   logic [4:0] c_dev;
   logic [2:0] c_fn;
   logic [11:0] c_off;
   logic in_window;
   logic [3:0] bus_bits;
   logic [31:0] win_size;
   logic [31:0] a32;
   logic is_node_dev;
   logic fn_impl;
   logic reg_impl;
   logic map_hit;

   // APB handshake: zero wait states, access phase completes at once
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = cur_ff.prdata;
   // Take requests in idle only, so none is dropped in the done cycle; hold posted writes while a config cycle is pending
   assign req_ready = !(req_posted && cur_ff.cfg_pending) && (cur_ff.st == NBR_ST_IDLE);
   assign rsp_valid = cur_ff.rsp_valid;
   assign rsp_dst = cur_ff.rsp_dst;
   assign rsp_addr = cur_ff.rsp_addr;
   assign rsp_rdata = cur_ff.rsp_rdata;
   assign rsp_fault = cur_ff.rsp_fault;
   assign rsp_link = cur_ff.rsp_link;

   // Window and configuration address decode
   always_comb begin
      a32 = req_addr[31:0];
      bus_bits = cur_ff.ctrl[CTRL_BUSN_LSB +: 4];
      if (bus_bits > 4'h8)
         bus_bits = 4'h8;
      // 1 MiB per bus, window sized by the supported bus count
      win_size = 32'h0010_0000 << bus_bits;
      in_window = cur_ff.ctrl[CTRL_MMCFG_EN] && req_addr[47:32] == 16'h0000 &&
                  a32 >= cur_ff.mmcfg_base && (a32 - cur_ff.mmcfg_base) < win_size;
      if (req_port_io) begin
         c_bus = cur_ff.port_addr[23:16];
         c_dev = cur_ff.port_addr[15:11];
         c_fn = cur_ff.port_addr[10:8];
         // Extended bits [27:24] count only when that path is opened
         c_off = {cur_ff.ctrl[CTRL_PORT_EXT_EN] ? cur_ff.port_addr[27:24] : 4'h0,
                  cur_ff.port_addr[7:2], req_addr[1:0]};
      end else begin
         // Offset into window: bus, device, function, offset
         {c_bus, c_dev, c_fn, c_off} = 28'(a32 - cur_ff.mmcfg_base);
      end
      is_node_dev = c_bus == 8'h00 && {3'h0, c_dev} >= NODE_DEV_FIRST &&
                    {3'h0, c_dev} <= NODE_DEV_LAST;
      fn_impl = cur_ff.ctrl[CTRL_FUNCS_LSB + c_fn];
      // Register file per function covers words 0..NUM_REGS-1 of 4096 bytes
      reg_impl = 32'(c_off[11:2]) < NUM_REGS;
      map_hit = cur_ff.cfgmap[CFGMAP_VALID] && c_bus >= cur_ff.cfgmap[7:0] &&
                c_bus <= cur_ff.cfgmap[15:8];
   end

   // Single next-state process for registers, routing and ordering
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.rsp_valid = 1'b0;
      // APB: writes act at the access phase; unmapped reads return zero
      if (psel && penable && pwrite) begin
         if (paddr == REG_CTRL)
            nxt_cur.ctrl = pwdata;
         else if (paddr == REG_MMCFG_BASE)
            nxt_cur.mmcfg_base = {pwdata[31:20], 20'h0_0000};
         else if (paddr == REG_MMIO_BASE)
            nxt_cur.mmio_base = pwdata;
         else if (paddr == REG_MMIO_LIMIT)
            nxt_cur.mmio_limit = pwdata;
         else if (paddr == REG_DRAM_BASE)
            nxt_cur.dram_base = pwdata;
         else if (paddr == REG_DRAM_LIMIT)
            nxt_cur.dram_limit = pwdata;
         else if (paddr == REG_IO_BASE)
            nxt_cur.io_base = pwdata;
         else if (paddr == REG_IO_LIMIT)
            nxt_cur.io_limit = pwdata;
         else if (paddr == REG_CFGMAP)
            nxt_cur.cfgmap = pwdata;
         else if (paddr == REG_SCRATCH)
            nxt_cur.scratch = pwdata;
      end
      if (psel && !penable && !pwrite) begin
         if (paddr == REG_CTRL)
            nxt_cur.prdata = cur_ff.ctrl;
         else if (paddr == REG_MMCFG_BASE)
            nxt_cur.prdata = cur_ff.mmcfg_base;
         else if (paddr == REG_MMIO_BASE)
            nxt_cur.prdata = cur_ff.mmio_base;
         else if (paddr == REG_MMIO_LIMIT)
            nxt_cur.prdata = cur_ff.mmio_limit;
         else if (paddr == REG_DRAM_BASE)
            nxt_cur.prdata = cur_ff.dram_base;
         else if (paddr == REG_DRAM_LIMIT)
            nxt_cur.prdata = cur_ff.dram_limit;
         else if (paddr == REG_IO_BASE)
            nxt_cur.prdata = cur_ff.io_base;
         else if (paddr == REG_IO_LIMIT)
            nxt_cur.prdata = cur_ff.io_limit;
         else if (paddr == REG_CFGMAP)
            nxt_cur.prdata = cur_ff.cfgmap;
         else if (paddr == REG_STATUS)
            nxt_cur.prdata = {14'h0000, cur_ff.cfg_pending, 1'b0, cur_ff.abort_cnt};
         else if (paddr == REG_SCRATCH)
            nxt_cur.prdata = cur_ff.scratch;
         else
            nxt_cur.prdata = 32'h0000_0000;
      end

      case (cur_ff.st)
         NBR_ST_IDLE: begin
            if (req_valid && req_ready) begin
               nxt_cur.st = NBR_ST_DONE;
               nxt_cur.rsp_valid = 1'b1;
               nxt_cur.rsp_fault = 1'b0;
               nxt_cur.rsp_rdata = 32'h0000_0000;
               nxt_cur.rsp_addr = req_addr;
               nxt_cur.rsp_link = '0;
               nxt_cur.rsp_dst = NBR_DST_LEGACY;
               if (req_port_io && req_space == NBR_SPACE_IO) begin
                  // Port config path: CF8h holds address, CFCh moves data
                  if (cur_ff.ctrl[CTRL_PORT_FAULT_EN] &&
                      (req_addr[15:0] == PORT_ADDR_IO || req_addr[15:2] == PORT_DATA_IO[15:2])) begin
                     nxt_cur.rsp_fault = 1'b1;
                     nxt_cur.rsp_dst = NBR_DST_NONE;
                  end else if (req_addr[15:0] == PORT_ADDR_IO) begin
                     nxt_cur.rsp_dst = NBR_DST_NONE;
                     if (req_write)
                        nxt_cur.port_addr = req_wdata;
                     nxt_cur.rsp_rdata = cur_ff.port_addr;
                  end else if (req_addr[15:2] == PORT_DATA_IO[15:2] &&
                               cur_ff.port_addr[31] && cur_ff.ctrl[CTRL_PORT_CFG_EN]) begin
                     if (is_node_dev) begin
                        nxt_cur.rsp_dst = NBR_DST_NONE;
                        nxt_cur.rsp_rdata = !fn_impl ? UNIMPL_FUNC_DATA :
                                            !reg_impl ? UNIMPL_REG_DATA : cur_ff.scratch;
                     end else if (!req_from_core) begin
                        nxt_cur.rsp_dst = NBR_DST_ABORT;
                     end else begin
                        nxt_cur.rsp_dst = NBR_DST_LINK;
                        nxt_cur.rsp_link = map_hit ? cur_ff.cfgmap[CFGMAP_LINK_LSB +: LINK_W] :
                                           cur_ff.ctrl[CTRL_SUBLINK_LSB +: LINK_W];
                        nxt_cur.rsp_addr = (c_off >= 12'(BASE_REGION_BYTES) ?
                                            LINK_EXT_CFG_ADDR : LINK_BASE_CFG_ADDR) +
                                           {20'h0_0000, c_bus, c_dev, c_fn, c_off};
                        nxt_cur.st = NBR_ST_WAIT;
                     end
                  end else if (req_addr[31:0] >= cur_ff.io_base &&
                               req_addr[31:0] <= cur_ff.io_limit) begin
                     nxt_cur.rsp_dst = NBR_DST_ROOT;
                  end
               end else if (req_space == NBR_SPACE_CFG || in_window) begin
                  if (!req_from_core) begin
                     nxt_cur.rsp_dst = NBR_DST_ABORT;
                  end else if (is_node_dev) begin
                     // Local node registers; no abort recorded on a miss
                     nxt_cur.rsp_dst = NBR_DST_NONE;
                     nxt_cur.rsp_rdata = !fn_impl ? UNIMPL_FUNC_DATA :
                                         !reg_impl ? UNIMPL_REG_DATA : cur_ff.scratch;
                  end else begin
                     // Foreign device: forward by map or subtractive link
                     nxt_cur.rsp_dst = NBR_DST_LINK;
                     nxt_cur.rsp_link = map_hit ? cur_ff.cfgmap[CFGMAP_LINK_LSB +: LINK_W] :
                                        cur_ff.ctrl[CTRL_SUBLINK_LSB +: LINK_W];
                     nxt_cur.rsp_addr = (c_off >= 12'(BASE_REGION_BYTES) ?
                                         LINK_EXT_CFG_ADDR : LINK_BASE_CFG_ADDR) +
                                        {20'h0_0000, c_bus, c_dev, c_fn, c_off};
                     nxt_cur.cfg_pending = in_window;
                     nxt_cur.st = NBR_ST_WAIT;
                  end
               end else if (req_space == NBR_SPACE_IO) begin
                  // Priority order: root, VGA, legacy
                  if (req_addr[31:0] >= cur_ff.io_base && req_addr[31:0] <= cur_ff.io_limit)
                     nxt_cur.rsp_dst = NBR_DST_ROOT;
                  else if (cur_ff.ctrl[CTRL_VGA_EN] && req_addr[31:0] >= VGA_IO_LO &&
                           req_addr[31:0] <= VGA_IO_HI)
                     nxt_cur.rsp_dst = NBR_DST_VGA;
               end else begin
                  // Memory space, one destination by priority
                  if (!req_from_core) begin
                     if (req_addr[31:0] >= cur_ff.mmio_base && req_addr[31:0] <= cur_ff.mmio_limit)
                        nxt_cur.rsp_dst = NBR_DST_ROOT;
                     else if (req_addr[31:0] >= cur_ff.dram_base &&
                              req_addr[31:0] <= cur_ff.dram_limit)
                        nxt_cur.rsp_dst = NBR_DST_DRAM;
                  end else if (req_dst_dram) begin
                     if (req_addr[31:0] >= cur_ff.dram_base && req_addr[31:0] <= cur_ff.dram_limit)
                        nxt_cur.rsp_dst = NBR_DST_DRAM;
                  end else begin
                     if (cur_ff.ctrl[CTRL_VGA_EN] && req_addr[31:0] >= VGA_MEM_LO &&
                         req_addr[31:0] <= VGA_MEM_HI)
                        nxt_cur.rsp_dst = NBR_DST_VGA;
                     else if (req_addr[31:0] >= cur_ff.mmio_base &&
                              req_addr[31:0] <= cur_ff.mmio_limit)
                        nxt_cur.rsp_dst = NBR_DST_ROOT;
                  end
                  // DRAM controllers see the offset inside their range only
                  if (nxt_cur.rsp_dst == NBR_DST_DRAM)
                     nxt_cur.rsp_addr = {16'h0000, req_addr[31:0] - cur_ff.dram_base};
               end
            end
         end
         NBR_ST_WAIT: begin
            // Forwarded config cycle outstanding; count aborts from the link
            if (cfg_done) begin
               nxt_cur.cfg_pending = 1'b0;
               if (cfg_master_abort)
                  nxt_cur.abort_cnt = cur_ff.abort_cnt + 16'h0001;
               nxt_cur.st = NBR_ST_DONE;
            end
         end
         NBR_ST_DONE: nxt_cur.st = NBR_ST_IDLE;
         default: nxt_cur.st = NBR_ST_IDLE;
      endcase
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff <= '0;
         cur_ff.st <= NBR_ST_IDLE;
         cur_ff.ctrl <= CTRL_RESET;
         cur_ff.mmcfg_base <= MMCFG_BASE_RESET;
         cur_ff.mmio_base <= BASE_RESET;
         cur_ff.dram_base <= BASE_RESET;
         cur_ff.io_base <= BASE_RESET;
         cur_ff.mmio_limit <= LIMIT_RESET;
         cur_ff.dram_limit <= LIMIT_RESET;
         cur_ff.io_limit <= LIMIT_RESET;
      end else if (clk_en) begin
         cur_ff <= nxt_cur;
      end
   end
endmodule

// ==== tb/nbr_router_asserts.sv ====
// Checker: port-level timing and routing properties of the request router
`timescale 1ns/1ps
module nbr_router_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_from_core,
   input wire logic [1:0] req_space,
   input wire logic rsp_valid,
   input wire logic [5:0] rsp_dst,
   input wire logic [47:0] rsp_addr,
   input wire logic cfg_done
);
   import nbr_pkg::*;
   // Request taken at this edge
   wire logic accept = req_valid && req_ready && clk_en;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_ANSWER: assert property (accept |=> rsp_valid ##1 !rsp_valid)
      else $error("accepted request got no single answer pulse");
   AST_ONE_DST: assert property (rsp_valid |-> $onehot0(rsp_dst))
      else $error("answer names more than one destination");
   AST_DONE_LOW: assert property (rsp_valid |-> !req_ready)
      else $error("request accepted while an answer is shown");
   AST_LINK_CFG_ABORT: assert property (accept && req_space == 2'h2 && !req_from_core
      |=> rsp_dst == NBR_DST_ABORT)
      else $error("config request from link not aborted");
   AST_WAIT_LINK: assert property (rsp_valid && rsp_dst == NBR_DST_LINK |=> !req_ready [*2])
      else $error("request taken while forwarded config cycle pending");
   AST_CFG_DONE: assert property (cfg_done && !req_ready |=> !req_ready ##1 req_ready)
      else $error("router not free two cycles after config completion");
   AST_HOLD: assert property (!rsp_valid |-> $stable(rsp_dst) && $stable(rsp_addr))
      else $error("answer fields changed without a new request");
   AST_APB_READY: assert property (psel && penable |-> pready && !pslverr)
      else $error("register access not answered cleanly");
endmodule

bind nbr_router nbr_router_asserts i_nbr_router_asserts (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .req_valid(req_valid), .req_ready(req_ready), .req_from_core(req_from_core),
   .req_space(req_space), .rsp_valid(rsp_valid), .rsp_dst(rsp_dst), .rsp_addr(rsp_addr),
   .cfg_done(cfg_done));

// ==== tb/nbr_far_model.sv ====
// Far-side model: completes forwarded configuration cycles
`timescale 1ns/1ps
module nbr_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rsp_valid,
   input wire logic [5:0] rsp_dst,
   input wire logic [7:0] delay,
   input wire logic abort_cmd,
   output logic cfg_done,
   output logic cfg_master_abort
);
   import nbr_pkg::*;
   int cnt;
   // Count down a forwarded cycle; abort only when the bench commands it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         cfg_done <= 1'b0;
         cfg_master_abort <= 1'b0;
      end else begin
         cfg_done <= 1'b0;
         cfg_master_abort <= 1'b0;
         if (rsp_valid && rsp_dst == NBR_DST_LINK) cnt <= int'(delay) + 1;
         else if (cnt == 1) begin
            cnt <= 0;
            cfg_done <= 1'b1;
            cfg_master_abort <= abort_cmd;
         end else if (cnt > 1) cnt <= cnt - 1;
      end
   end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the request router
`timescale 1ns/1ps
module testbench;
   import nbr_pkg::*;
   localparam logic [31:0] MM_B = 32'h8000_0000, MM_L = 32'h8FFF_FFFF, DR_B = 32'h0100_0000;
   localparam logic [31:0] DR_L = 32'h3FFF_FFFF, IO_B = 32'h0000_1000, IO_L = 32'h0000_1FFF;
   localparam logic [31:0] SCR = 32'h5A5A_C3C3, CTL = 32'h0001_1000;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, req_valid = 1'b0, req_from_core = 1'b0, req_dst_dram = 1'b0;
   logic req_write = 1'b0, req_posted = 1'b0, req_port_io = 1'b0, far_abort = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, req_wdata = 32'h0, prdata, rsp_rdata, rd, a;
   logic [1:0] req_space = 2'h0, rsp_link, sp;
   logic [47:0] req_addr = 48'h0, rsp_addr;
   logic [5:0] rsp_dst, e;
   logic [7:0] far_delay = 8'h00;
   logic pready, pslverr, req_ready, rsp_valid, rsp_fault, cfg_done, cfg_master_abort;
   logic vga = 1'b0, core, dram;
   logic [11:0] ra[6] = '{12'h100, REG_CTRL, REG_MMCFG_BASE, REG_MMIO_BASE, REG_MMIO_LIMIT,
      REG_IO_BASE};
   logic [31:0] rv[6] = '{32'h0, CTRL_RESET, MMCFG_BASE_RESET, BASE_RESET, LIMIT_RESET, BASE_RESET};
   logic [11:0] wa[9] = '{REG_MMIO_BASE, REG_MMIO_LIMIT, REG_DRAM_BASE, REG_DRAM_LIMIT,
      REG_IO_BASE, REG_IO_LIMIT, REG_CFGMAP, REG_CTRL, REG_SCRATCH};
   logic [31:0] wv[9] = '{MM_B, MM_L, DR_B, DR_L, IO_B, IO_L, 32'h8002_0101, CTL, SCR};
   int num_errors = 0, checked = 0;
   realtime t0;

   // Free-running bus clock
   always #5 pclk = ~pclk;

   nbr_router #(.LINK_W(2)) i_nbr_router (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
      .req_ready(req_ready), .req_from_core(req_from_core), .req_space(req_space),
      .req_dst_dram(req_dst_dram), .req_write(req_write), .req_posted(req_posted),
      .req_port_io(req_port_io), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_dst(rsp_dst), .rsp_addr(rsp_addr), .rsp_rdata(rsp_rdata),
      .rsp_fault(rsp_fault), .rsp_link(rsp_link), .cfg_done(cfg_done),
      .cfg_master_abort(cfg_master_abort));
   nbr_far_model i_nbr_far_model (.pclk(pclk), .presetn(presetn), .rsp_valid(rsp_valid),
      .rsp_dst(rsp_dst), .delay(far_delay), .abort_cmd(far_abort), .cfg_done(cfg_done),
      .cfg_master_abort(cfg_master_abort));

   // Verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo();
      num_errors++;
      $display("wrong value at %0t: no handshake", $time);
      stop_test();
   endtask
   // One APB transfer; read data lands in rd
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) tmo();
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Request held until taken; answer sampled mid-cycle after
   task automatic req(input logic c, input logic [1:0] s, input logic d, input logic w,
      input logic p, input logic io, input logic [47:0] ad, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      req_valid <= 1'b1;
      req_from_core <= c;
      req_space <= s;
      req_dst_dram <= d;
      req_write <= w | p;
      req_posted <= p;
      req_port_io <= io;
      req_addr <= ad;
      req_wdata <= wd;
      for (n = 0; n < 300; n++) begin
         @(posedge pclk);
         if (req_ready === 1'b1) break;
      end
      if (n == 300) tmo();
      req_valid <= 1'b0;
      @(negedge pclk);
      chk(rsp_valid, 1'b1);
   endtask
   // Destination by source, space and priority of matches
   function automatic logic [5:0] exp_dst(logic c, logic [1:0] s, logic d, logic [31:0] x);
      logic mm, dr, io, vm, vi;
      mm = x >= MM_B && x <= MM_L;
      dr = x >= DR_B && x <= DR_L;
      io = x >= IO_B && x <= IO_L;
      vm = vga && x >= VGA_MEM_LO && x <= VGA_MEM_HI;
      vi = vga && x >= VGA_IO_LO && x <= VGA_IO_HI;
      if (s == 2'h1) return io ? NBR_DST_ROOT : vi ? NBR_DST_VGA : NBR_DST_LEGACY;
      if (!c) return mm ? NBR_DST_ROOT : dr ? NBR_DST_DRAM : NBR_DST_LEGACY;
      if (d) return dr ? NBR_DST_DRAM : NBR_DST_LEGACY;
      return vm ? NBR_DST_VGA : mm ? NBR_DST_ROOT : NBR_DST_LEGACY;
   endfunction
   // Configuration address: bus, device, function, byte offset
   function automatic logic [47:0] cfa(logic [7:0] b, logic [4:0] d, logic [2:0] f,
      logic [11:0] o);
      return {20'h0, b, d, f, o};
   endfunction

   // Main sequence
   initial begin
      rd = $urandom(32'h27703299);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, 12'h100, 32'hFFFF_FFFF);
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      foreach (wa[i]) apb(1'b1, wa[i], wv[i]);
      apb(1'b0, REG_SCRATCH, 32'h0);
      chk(rd, SCR);
      for (int i = 0; i < 60; i++) begin
         if (i == 30) vga = 1'b1;
         if (i == 30) apb(1'b1, REG_CTRL, CTL | (32'h1 << CTRL_VGA_EN));
         if (i == 10) begin
            @(posedge pclk);
            clk_en <= 1'b0;
            repeat (3) @(posedge pclk);
            clk_en <= 1'b1;
         end
         core = 1'($urandom);
         sp = 2'($urandom % 2);
         dram = 1'($urandom);
         case ($urandom % 5)
            0: a = MM_B + $urandom % 32'h1000_0000;
            1: a = DR_B + $urandom % 32'h3F00_0000;
            2: a = VGA_MEM_LO + $urandom % 32'h0002_0000;
            3: a = IO_B + $urandom % 32'h0000_1000;
            default: a = VGA_IO_LO + $urandom % 32'h0000_0030;
         endcase
         a = a & 32'hFFFF_FFFC;
         req(core, sp, dram, 1'($urandom), 1'b0, 1'b0, {16'h0, a}, $urandom);
         e = exp_dst(core, sp, dram, a);
         chk(rsp_dst, e);
         if (e == NBR_DST_DRAM) chk(rsp_addr, {16'h0, a - DR_B});
      end
      req(1'b0, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, cfa(8'h01, 5'h00, 3'h0, 12'h000), 32'h0);
      chk(rsp_dst, NBR_DST_ABORT);
      req(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, cfa(8'h00, 5'h18, 3'h0, 12'h010), 32'h0);
      chk(rsp_dst, NBR_DST_NONE);
      chk(rsp_rdata, SCR);
      req(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, cfa(8'h00, 5'h18, 3'h0, 12'h800), 32'h0);
      chk(rsp_rdata, UNIMPL_REG_DATA);
      req(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, cfa(8'h00, 5'h18, 3'h3, 12'h010), 32'h0);
      chk(rsp_rdata, UNIMPL_FUNC_DATA);
      // Slow far side: the posted write behind must wait for completion
      far_delay <= 8'd20;
      t0 = $realtime;
      req(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, cfa(8'h01, 5'h00, 3'h0, 12'h000), 32'h0);
      chk(rsp_dst, NBR_DST_LINK);
      chk(rsp_link, 2'h2);
      chk(rsp_addr, LINK_BASE_CFG_ADDR + cfa(8'h01, 5'h00, 3'h0, 12'h000));
      req(1'b1, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0, {16'h0, MM_B}, 32'h1234_5678);
      chk($realtime - t0 > 200.0, 1'b1);
      far_delay <= 8'd0;
      far_abort <= 1'b1;
      req(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, cfa(8'h05, 5'h00, 3'h0, 12'h000), 32'h0);
      chk(rsp_link, 2'h1);
      apb(1'b1, REG_CTRL, CTL | (32'h1 << CTRL_PORT_FAULT_EN));
      req(1'b1, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, {32'h0, PORT_ADDR_IO}, 32'h8000_C010);
      chk(rsp_fault, 1'b1);
      apb(1'b1, REG_CTRL, CTL | (32'h1 << CTRL_PORT_CFG_EN));
      req(1'b1, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, {32'h0, PORT_ADDR_IO}, 32'h8000_C010);
      req(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, {32'h0, PORT_DATA_IO}, 32'h0);
      chk(rsp_fault, 1'b0);
      chk(rsp_rdata, SCR);
      req(1'b1, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, {32'h0, PORT_ADDR_IO}, 32'h8100_C010);
      req(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, {32'h0, PORT_DATA_IO}, 32'h0);
      chk(rsp_rdata, SCR);
      apb(1'b1, REG_CTRL, CTL | 32'h13);
      req(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, {32'h0, PORT_DATA_IO}, 32'h0);
      chk(rsp_rdata, UNIMPL_REG_DATA);
      req(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0,
         {16'h0, MMCFG_BASE_RESET} + cfa(8'h00, 5'h18, 3'h0, 12'h010), 32'h0);
      chk(rsp_rdata, SCR);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[15:0], 16'h0001);
      stop_test();
   end
endmodule
